// *** logic/tlf_top.sv ***
// Purpose: temperature limits and programmable cold fault response
// Assumes: command port, reading and control inputs come from logic on ref_clk
// Notes: a restart attempt succeeds when the cold fault is gone at the end of its off delay
`timescale 1ns/1ps
module tlf_top import tlf_pkg::*; #(
    parameter int UNIT_W = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // command port
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_rvalid,
    output logic cmd_unsupported,
    // measurement and delay unit
    input wire logic [15:0] temp_reading,
    input wire logic [UNIT_W-1:0] unit_cycles,
    // fault clearing and on/off request
    input wire logic on_request,
    input wire logic clear_faults,
    input wire logic clear_cold_fault_bit,
    // status and output control
    output logic hot_warning,
    output logic cold_warning,
    output logic cold_fault,
    output logic cold_fault_status,
    output logic output_enable,
    output logic [2:0] attempts_used
);

    typedef struct packed {
        logic [15:0] hot_warning_threshold;
        logic [15:0] cold_warning_threshold;
        logic [15:0] cold_fault_threshold;
        logic [7:0] cold_fault_action_select;
        tlf_state_t state;
        logic [2:0] attempts;
        logic hot_warn;
        logic cold_warn;
        logic fault_now;
        logic status;
        logic out_en;
        logic [15:0] rdata;
        logic rvalid;
        logic bad_cmd;
    } tlf_top_state_t;

    tlf_top_state_t s;
    tlf_top_state_t next_s;
    logic timer_start;
    logic timer_done;
    logic [1:0] action;
    logic [2:0] retries;
    logic signed [FIX_W-1:0] temp_fix;

    assign action = s.cold_fault_action_select[ACT_MSB:ACT_LSB];
    assign retries = s.cold_fault_action_select[RETRY_MSB:RETRY_LSB];
    assign temp_fix = tlf_lin_to_fix(temp_reading);

    tlf_delay_timer #(
        .UNIT_W(UNIT_W),
        .CODE_W(3),
        .COUNT_W(8)
    ) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(timer_start),
        .delay_code(s.cold_fault_action_select[DELAY_MSB:DELAY_LSB]),
        .unit_cycles(unit_cycles),
        .done(timer_done)
    );

    always_comb begin
        logic fault_rise;
        logic cleared;
        fault_rise = 1'b0;
        cleared = 1'b0;
        next_s = s;
        timer_start = 1'b0;
        next_s.rvalid = 1'b0;
        next_s.bad_cmd = 1'b0;

        // comparisons on linear values
        next_s.hot_warn = temp_fix > tlf_lin_to_fix(s.hot_warning_threshold);
        next_s.cold_warn = temp_fix < tlf_lin_to_fix(s.cold_warning_threshold);
        next_s.fault_now = temp_fix < tlf_lin_to_fix(s.cold_fault_threshold);
        fault_rise = next_s.fault_now && !s.fault_now;

        // command writes and reads
        if (cmd_write) begin
            unique case (cmd_code)
                CMD_HOT_WARNING_THRESHOLD: next_s.hot_warning_threshold = cmd_wdata;
                CMD_COLD_WARNING_THRESHOLD: next_s.cold_warning_threshold = cmd_wdata;
                CMD_COLD_FAULT_THRESHOLD: next_s.cold_fault_threshold = cmd_wdata;
                CMD_COLD_FAULT_ACTION_SELECT: next_s.cold_fault_action_select = cmd_wdata[7:0];
                default: next_s.bad_cmd = 1'b1;
            endcase
        end
        if (cmd_read) begin
            next_s.rvalid = 1'b1;
            unique case (cmd_code)
                CMD_HOT_WARNING_THRESHOLD: next_s.rdata = s.hot_warning_threshold;
                CMD_COLD_WARNING_THRESHOLD: next_s.rdata = s.cold_warning_threshold;
                CMD_COLD_FAULT_THRESHOLD: next_s.rdata = s.cold_fault_threshold;
                CMD_COLD_FAULT_ACTION_SELECT: next_s.rdata = {8'h00, s.cold_fault_action_select};
                default: begin
                    next_s.rdata = 16'h0000;
                    next_s.bad_cmd = 1'b1;
                end
            endcase
        end

        // sticky status: a new fault edge beats a clear in the same cycle
        if (clear_faults || clear_cold_fault_bit) begin
            next_s.status = 1'b0;
        end
        if (fault_rise) begin
            next_s.status = 1'b1;
        end
        cleared = clear_faults || clear_cold_fault_bit;

        // response sequence
        unique case (s.state)
            ST_NORMAL: begin
                if (next_s.fault_now && on_request) begin
                    unique case (action)
                        ACT_IGNORE: next_s.state = ST_NORMAL;
                        ACT_RIDE_THROUGH: begin
                            next_s.state = ST_RIDE;
                            timer_start = 1'b1;
                        end
                        ACT_DISABLE_RETRY: begin
                            next_s.attempts = 3'h0;
                            if (retries == RETRY_NONE) begin
                                next_s.state = ST_LATCHED;
                            end else begin
                                next_s.state = ST_OFF_WAIT;
                                timer_start = 1'b1;
                            end
                        end
                        ACT_LATCH_OFF: next_s.state = ST_LATCHED;
                    endcase
                end
            end
            ST_RIDE: begin
                if (!next_s.fault_now) begin
                    next_s.state = ST_NORMAL;
                end else if (timer_done) begin
                    next_s.attempts = 3'h0;
                    if (retries == RETRY_NONE) begin
                        next_s.state = ST_LATCHED;
                    end else begin
                        next_s.state = ST_OFF_WAIT;
                        timer_start = 1'b1;
                    end
                end
            end
            ST_OFF_WAIT: begin
                if (timer_done) begin
                    if (!next_s.fault_now) begin
                        next_s.state = ST_NORMAL;
                        next_s.attempts = 3'h0;
                    end else if (retries == RETRY_ENDLESS) begin
                        timer_start = 1'b1;
                    end else if (s.attempts + 3'h1 >= retries) begin
                        next_s.attempts = s.attempts + 3'h1;
                        next_s.state = ST_LATCHED;
                    end else begin
                        next_s.attempts = s.attempts + 3'h1;
                        timer_start = 1'b1;
                    end
                end
            end
            ST_LATCHED: begin
                if (cleared) begin
                    next_s.state = ST_NORMAL;
                    next_s.attempts = 3'h0;
                end
            end
        endcase

        // commanded off ends any sequence; off then on restarts clean
        if (!on_request) begin
            next_s.state = ST_NORMAL;
            next_s.attempts = 3'h0;
        end

        next_s.out_en = on_request &&
            (next_s.state == ST_NORMAL || next_s.state == ST_RIDE);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '{
                hot_warning_threshold: RST_HOT_WARNING_THRESHOLD,
                cold_warning_threshold: RST_COLD_WARNING_THRESHOLD,
                cold_fault_threshold: RST_COLD_FAULT_THRESHOLD,
                cold_fault_action_select: RST_COLD_FAULT_ACTION_SELECT,
                state: ST_NORMAL,
                default: '0
            };
        end else begin
            s <= next_s;
        end
    end

    assign cmd_rdata = s.rdata;
    assign cmd_rvalid = s.rvalid;
    assign cmd_unsupported = s.bad_cmd;
    assign hot_warning = s.hot_warn;
    assign cold_warning = s.cold_warn;
    assign cold_fault = s.fault_now;
    assign cold_fault_status = s.status;
    assign output_enable = s.out_en;
    assign attempts_used = s.attempts;

endmodule : tlf_top

// *** logic/tlf_pkg.sv ***
// Purpose: shared constants and types for the cold fault response block
// Assumes: thresholds and readings use the 16-bit linear number format
// Notes: reset values of the limit registers are plain defaults
package tlf_pkg;

    // command codes of the limit and response registers
    localparam logic [7:0] CMD_HOT_WARNING_THRESHOLD = 8'h51;
    localparam logic [7:0] CMD_COLD_WARNING_THRESHOLD = 8'h52;
    localparam logic [7:0] CMD_COLD_FAULT_THRESHOLD = 8'h53;
    localparam logic [7:0] CMD_COLD_FAULT_ACTION_SELECT = 8'h54;

    // reset values
    localparam logic [15:0] RST_HOT_WARNING_THRESHOLD = 16'h0000;
    localparam logic [15:0] RST_COLD_WARNING_THRESHOLD = 16'h0000;
    localparam logic [15:0] RST_COLD_FAULT_THRESHOLD = 16'h0000;
    localparam logic [7:0] RST_COLD_FAULT_ACTION_SELECT = 8'h00;

    // action select fields
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_RIDE_THROUGH = 2'h1;
    localparam logic [1:0] ACT_DISABLE_RETRY = 2'h2;
    localparam logic [1:0] ACT_LATCH_OFF = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // linear format fields
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MAN_MSB = 10;
    localparam int LIN_MAN_LSB = 0;
    localparam logic [6:0] LIN_FRAC_BITS = 7'h10;
    localparam int FIX_W = 48;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_RIDE = 2'b01,
        ST_OFF_WAIT = 2'b10,
        ST_LATCHED = 2'b11
    } tlf_state_t;

    // linear value to signed fixed point with 16 fraction bits
    function automatic logic signed [FIX_W-1:0] tlf_lin_to_fix(input logic [15:0] v);
        logic signed [6:0] sh;
        logic signed [FIX_W-1:0] m;
        sh = 7'(signed'(v[LIN_EXP_MSB:LIN_EXP_LSB])) + signed'(LIN_FRAC_BITS);
        m = FIX_W'(signed'(v[LIN_MAN_MSB:LIN_MAN_LSB]));
        return m <<< sh[5:0];
    endfunction : tlf_lin_to_fix

endpackage : tlf_pkg

// *** logic/tlf_delay_timer.sv ***
// Purpose: delay of 2^code delay time units, one done pulse at the end
// Assumes: unit_cycles is the unit length in ref_clk cycles, zero taken as one
// Notes: a start pulse restarts a running delay
`timescale 1ns/1ps
module tlf_delay_timer import tlf_pkg::*; #(
    parameter int UNIT_W = 16,
    parameter int CODE_W = 3,
    parameter int COUNT_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic start,
    input wire logic [CODE_W-1:0] delay_code,
    input wire logic [UNIT_W-1:0] unit_cycles,
    // result
    output logic done
);

    typedef struct packed {
        logic [UNIT_W-1:0] pre;
        logic [COUNT_W-1:0] units;
        logic run;
        logic done;
    } tlf_timer_t;

    tlf_timer_t s;
    tlf_timer_t next_s;
    logic [COUNT_W-1:0] last_unit;
    logic unit_tick;

    // code n spans 2^n units: 1, 2, 4 .. 128
    assign last_unit = COUNT_W'((COUNT_W+1)'(1) << delay_code) - COUNT_W'(1);
    assign unit_tick = (s.pre == unit_cycles - UNIT_W'(1)) || (unit_cycles == '0);

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (start) begin
            next_s.pre = '0;
            next_s.units = '0;
            next_s.run = 1'b1;
        end else if (s.run) begin
            if (unit_tick) begin
                next_s.pre = '0;
                if (s.units == last_unit) begin
                    next_s.run = 1'b0;
                    next_s.done = 1'b1;
                end else begin
                    next_s.units = s.units + COUNT_W'(1);
                end
            end else begin
                next_s.pre = s.pre + UNIT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

endmodule : tlf_delay_timer

// *** bench/tlf_chk_sva.sv ***
// Purpose: port assertions for the cold fault response block
// Assumes: one clock, reset active low
// Notes: action byte shadowed from port writes, so no internal probes
`timescale 1ns/1ps
module tlf_chk import tlf_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // command port
    input wire logic [7:0] cmd_code,
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_unsupported,
    // control and status
    input wire logic on_request,
    input wire logic clear_faults,
    input wire logic clear_cold_fault_bit,
    input wire logic cold_fault,
    input wire logic cold_fault_status,
    input wire logic output_enable
);
    logic [7:0] sel;
    logic mapped;
    logic hold_off;
    assign mapped = cmd_code inside {[8'h51:8'h54]};
    assign hold_off = sel[7:6] == ACT_LATCH_OFF || sel[7:3] == {ACT_DISABLE_RETRY, RETRY_NONE};
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel <= 8'h00;
        end else if (cmd_write && cmd_code == CMD_COLD_FAULT_ACTION_SELECT) begin
            sel <= cmd_wdata[7:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_READ_ANSWER: assert property (cmd_read && mapped |=> cmd_rvalid)
        else $error("mapped read not answered");
    AST_REFUSE_CODE: assert property ((cmd_read || cmd_write) && !mapped |=> cmd_unsupported)
        else $error("unmapped code not refused");
    AST_BYTE_READ: assert property (cmd_read && !cmd_write && cmd_code == CMD_COLD_FAULT_ACTION_SELECT
        |=> cmd_rdata == {8'h00, sel}) else $error("action byte read wrong");
    AST_IGNORE: assert property (sel[7:6] == ACT_IGNORE && !cmd_write && on_request && output_enable
        |=> output_enable) else $error("output dropped while ignoring");
    AST_SHUT_AT_ONCE: assert property ($rose(cold_fault) && $past(on_request) && $past(output_enable)
        && !$past(cmd_write) && sel[7] |-> !output_enable) else $error("output not shut with fault");
    AST_HOLD_OFF: assert property (hold_off && !output_enable && cold_fault_status && on_request
        && $past(on_request) && !clear_faults && !clear_cold_fault_bit && !cmd_write |=> !output_enable)
        else $error("output restarted without clear");
    AST_RIDE_ON: assert property (sel[7:6] == ACT_RIDE_THROUGH && $rose(cold_fault) && $past(output_enable)
        && $past(on_request) && !$past(cmd_write) |-> output_enable) else $error("ride through stopped");
    AST_STATUS_SET: assert property ($rose(cold_fault) |-> cold_fault_status)
        else $error("status not set on fault");
endmodule : tlf_chk
bind tlf_top tlf_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_unsupported(cmd_unsupported), .on_request(on_request), .clear_faults(clear_faults),
    .clear_cold_fault_bit(clear_cold_fault_bit), .cold_fault(cold_fault), .cold_fault_status(cold_fault_status),
    .output_enable(output_enable));

// *** bench/tlf_host.sv ***
// Purpose: management host model driving the command port
// Assumes: request launched at falling edge, taken at next rising edge
// Notes: gap adds idle cycles to act as a slow host
`timescale 1ns/1ps
module tlf_host (
    // clock
    input wire logic ref_clk,
    // command port
    output logic [7:0] cmd_code,
    output logic cmd_write,
    output logic cmd_read,
    output logic [15:0] cmd_wdata
);
    initial begin
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_wdata = 16'h0000;
    end
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data, input int gap);
        @(negedge ref_clk);
        cmd_code = code;
        cmd_wdata = data;
        cmd_write = wr;
        cmd_read = !wr;
        @(negedge ref_clk);
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        // idle lines show garbage, never the last value
        cmd_wdata = ~data;
        cmd_code = ~code;
        repeat (gap) @(negedge ref_clk);
    endtask : access
endmodule : tlf_host

// *** bench/test_tlf_top.sv ***
// Purpose: self-checking bench for the cold fault response block
// Assumes: thresholds use exponent zero, so plain degrees
// Notes: delay spans measured against the shortest code
`timescale 1ns/1ps
module test_tlf_top import tlf_pkg::*; ;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] cmd_code;
    logic cmd_write, cmd_read, cmd_rvalid, cmd_unsupported;
    logic [15:0] cmd_wdata, cmd_rdata, v;
    logic [15:0] temp_reading = 16'h0028;
    logic [15:0] unit_cycles = 16'h0001;
    logic on_request = 1'b1;
    logic clear_faults = 1'b0;
    logic clear_cold_fault_bit = 1'b0;
    logic hot_warning, cold_warning, cold_fault, cold_fault_status, output_enable;
    logic [2:0] attempts_used;
    logic [15:0] exp_q[$];
    logic uns_q[$];
    int bad_count = 0;
    int check_count = 0;
    int n0, n;
    always #25 ref_clk = ~ref_clk;
    tlf_host i_host (.ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read),
        .cmd_wdata(cmd_wdata));
    tlf_top #(.UNIT_W(16)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .cmd_code(cmd_code), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_unsupported(cmd_unsupported), .temp_reading(temp_reading), .unit_cycles(unit_cycles),
        .on_request(on_request), .clear_faults(clear_faults), .clear_cold_fault_bit(clear_cold_fault_bit),
        .hot_warning(hot_warning), .cold_warning(cold_warning), .cold_fault(cold_fault),
        .cold_fault_status(cold_fault_status), .output_enable(output_enable), .attempts_used(attempts_used));
    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask : cmp_bit
    // unmapped codes owe one refusal pulse each
    task automatic note_refusal(input logic [7:0] c);
        if (!(c inside {[CMD_HOT_WARNING_THRESHOLD:CMD_COLD_FAULT_ACTION_SELECT]})) begin
            uns_q.push_back(1'b1);
        end
    endtask : note_refusal
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        note_refusal(c);
        i_host.access(1'b1, c, d, $urandom_range(1));
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        note_refusal(c);
        exp_q.push_back(e);
        i_host.access(1'b0, c, 16'h0000, $urandom_range(1));
    endtask : rd
    task automatic wait_n(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : wait_n
    task automatic clear(input logic bit_only);
        @(negedge ref_clk);
        clear_faults = !bit_only;
        clear_cold_fault_bit = bit_only;
        @(negedge ref_clk);
        clear_faults = 1'b0;
        clear_cold_fault_bit = 1'b0;
        wait_n(3);
    endtask : clear
    task automatic go_cold(input logic [7:0] s, input int k);
        wr(CMD_COLD_FAULT_ACTION_SELECT, {8'h00, s});
        temp_reading = 16'h000A;
        wait_n(k);
    endtask : go_cold
    task automatic measure(input logic [2:0] code, output int k);
        k = 0;
        go_cold({ACT_DISABLE_RETRY, 3'h1, code}, 0);
        while (attempts_used !== 3'h1 && k < 400) begin
            wait_n(1);
            k++;
        end
        temp_reading = 16'h0028;
        clear(1'b0);
    endtask : measure
    task automatic summarize;
        cmp_word("pending notes", 16'h0000, 16'(exp_q.size() + uns_q.size()));
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    always @(negedge ref_clk) begin
        if (cmd_rvalid === 1'b1) begin
            cmp_word("cmd_rdata", exp_q.size() > 0 ? exp_q.pop_front() : 16'hDEAD, cmd_rdata);
        end
        if (cmd_unsupported === 1'b1) begin
            cmp_bit("cmd_unsupported", uns_q.size() > 0 ? uns_q.pop_front() : 1'b0, cmd_unsupported);
        end
    end
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        v = 16'($urandom(32'hED9E));
        wait_n(2);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(CMD_HOT_WARNING_THRESHOLD + 8'(i), 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom());
            // a random action could start a sequence the later checks do not expect
            if (i == 3) begin
                v[ACT_MSB:ACT_LSB] = ACT_IGNORE;
            end
            wr(CMD_HOT_WARNING_THRESHOLD + 8'(i), v);
            rd(CMD_HOT_WARNING_THRESHOLD + 8'(i), i == 3 ? {8'h00, v[7:0]} : v);
        end
        rd(8'h60, 16'h0000);
        wr(CMD_HOT_WARNING_THRESHOLD, 16'h0032);
        wr(CMD_COLD_WARNING_THRESHOLD, 16'h001E);
        wr(CMD_COLD_FAULT_THRESHOLD, 16'h0014);
        wr(8'h60, 16'h0000);
        rd(CMD_COLD_FAULT_THRESHOLD, 16'h0014);
        temp_reading = 16'h003C;
        clear(1'b0);
        cmp_bit("hot_warning", 1'b1, hot_warning);
        temp_reading = 16'h0019;
        wait_n(3);
        cmp_bit("cold_warning", 1'b1, cold_warning);
        cmp_bit("cold_fault", 1'b0, cold_fault);
        go_cold({ACT_IGNORE, 6'h00}, 10);
        cmp_bit("cold_fault", 1'b1, cold_fault);
        cmp_bit("output_enable", 1'b1, output_enable);
        for (int r = 0; r < 8; r++) begin
            go_cold({ACT_DISABLE_RETRY, 3'(r), 3'h0}, 2);
            cmp_bit("output_enable", 1'b0, output_enable);
            cmp_bit("cold_fault_status", 1'b1, cold_fault_status);
            wait_n(40);
            cmp_bit("output_enable", 1'b0, output_enable);
            // endless retry keeps no count of failed attempts
            cmp_word("attempts_used", r < 7 ? 16'(r) : 16'h0000, {13'h0000, attempts_used});
            temp_reading = 16'h0028;
            on_request = r != 7;
            clear(r == 3);
            on_request = 1'b1;
            wait_n(3);
            cmp_bit("output_enable", 1'b1, output_enable);
            cmp_bit("cold_fault_status", 1'b0, cold_fault_status);
        end
        measure(3'h0, n0);
        for (int c = 1; c < 8; c++) begin
            measure(3'(c), n);
            cmp_word("retry span", 16'(n0 + (1 << c) - 1), 16'(n));
        end
        unit_cycles = 16'h0003;
        measure(3'h2, n);
        cmp_word("retry span", 16'(n0 + 11), 16'(n));
        unit_cycles = 16'h0002;
        go_cold({ACT_RIDE_THROUGH, 3'h0, 3'h2}, 4);
        cmp_bit("output_enable", 1'b1, output_enable);
        wait_n(20);
        cmp_bit("output_enable", 1'b0, output_enable);
        temp_reading = 16'h0028;
        clear(1'b0);
        go_cold({ACT_LATCH_OFF, 6'h00}, 3);
        temp_reading = 16'h0028;
        wait_n(10);
        cmp_bit("output_enable", 1'b0, output_enable);
        clear(1'b1);
        cmp_bit("output_enable", 1'b1, output_enable);
        summarize();
    end
endmodule : test_tlf_top
